// ---- rtl/srl_ctrl.v ----
// Reset, bootstrap entry, memory size and tamper erase control
`timescale 1ns/100ps
`include "srl_map.vh"
module srl_ctrl
(
  input wire ref_clk,
  input wire rstn,
  input wire reset_in,
  input wire loader_request,
  input wire low_supply_reset_in,
  input wire supply_below_min,
  input wire supply_below_backup,
  input wire tamper_destruct_input,
  input wire key_probe_detect,
  input wire memory_size_select,
  input wire lock_clear_req,
  input wire lock_set_req,
  input wire key_load_req,
  input wire [63:0] rng_key,
  input wire mem_req,
  input wire mem_loader_request,
  input wire [15:0] mem_addr,
  input wire vec_we,
  input wire [5:0] vec_addr,
  input wire [7:0] vec_wdata,
  output reg [7:0] vec_rdata,
  output reg core_reset,
  output reg loader_active,
  output reg low_supply_reset_out,
  output reg low_supply_reset_oe,
  output reg backup_active_flag,
  output reg backed_supply_output,
  output reg erase_busy,
  output reg lock_state,
  output reg [63:0] key_word,
  output reg [14:0] sram_addr,
  output reg sram_select_one,
  output reg sram_select_two,
  output reg sram_select_three,
  output reg sram_select_four
);
  // Two-stage synchronizers; first stage read only by the second
  reg [1:0] rst_sync_q;
  reg [1:0] ldr_sync_q;
  reg [1:0] lsr_sync_q;
  reg [1:0] tmp_sync_q;
  // Mode, erase pointer and edge history
  reg ldr_prev_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [5:0] erase_ptr_q;
  reg tamper_latch_q;
  reg boot_seen_q;
  // Decoded events and memory port nets
  wire rst_s;
  wire ldr_s;
  wire lsr_low_s;
  wire tmp_s;
  wire ldr_fall;
  wire any_reset;
  wire start_erase;
  wire [7:0] ram_rdata;
  wire ram_we;
  wire [5:0] ram_waddr;
  wire [7:0] ram_wdata;

  // Decode a 32kB block number into active-low selects
  function [3:0] blk_sel;
    input [1:0] blk;
    begin
      blk_sel = ~(4'h1 << blk);
    end
  endfunction

  // True while the mode owns the vector memory for wiping
  function is_erase;
    input [1:0] st;
    begin
      is_erase = (st == `SRL_ST_ERASE);
    end
  endfunction

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Reset pin taken as active until it has passed both stages
      rst_sync_q <= 2'h3;
      ldr_sync_q <= 2'h3; // Pull-up idles high
      lsr_sync_q <= 2'h3;
      tmp_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], reset_in};
      ldr_sync_q <= {ldr_sync_q[0], loader_request};
      lsr_sync_q <= {lsr_sync_q[0], low_supply_reset_in};
      tmp_sync_q <= {tmp_sync_q[0], tamper_destruct_input};
    end
  end

  // Synchronized levels and the loader edge
  assign rst_s = rst_sync_q[1];
  assign ldr_s = ldr_sync_q[1];
  assign lsr_low_s = ~lsr_sync_q[1];
  assign tmp_s = tmp_sync_q[1];
  assign ldr_fall = ldr_prev_q & ~ldr_s;
  // Own pin low counts as reset too, so peers and self stay in step
  assign any_reset = rst_s | lsr_low_s | supply_below_min;
  // Probe detection treated like tamper: key cannot survive it
  assign start_erase = tmp_s | key_probe_detect | lock_clear_req;

  // Edge history on the synchronized request; the hold time is the
  // requester's duty, so entry is not gated on a low-level count
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Starts high like the pulled-up pin, so reset gives no false edge
      ldr_prev_q <= 1'b1;
      boot_seen_q <= 1'b0;
    end
    else
    begin
      ldr_prev_q <= ldr_s;
      boot_seen_q <= 1'b1;
    end
  end

  // Mode sequencer; erase wins over all and reset cannot cut it short
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `SRL_ST_RUN:
      begin
        // Reset outranks a loader request
        if (any_reset)
          state_d = `SRL_ST_RESET;
        else if (ldr_fall || !boot_seen_q && !ldr_s)
          state_d = `SRL_ST_LOADER;
      end
      `SRL_ST_RESET:
      begin
        // Request level at release picks loader or run
        if (!any_reset)
          state_d = ldr_s ? `SRL_ST_RUN : `SRL_ST_LOADER;
      end
      `SRL_ST_LOADER:
      begin
        // Loader ends when the request pin returns high
        if (any_reset)
          state_d = `SRL_ST_RESET;
        else if (ldr_s)
          state_d = `SRL_ST_RUN;
      end
      `SRL_ST_ERASE:
      begin
        // All bytes written and tamper gone before leaving
        if (erase_ptr_q == `SRL_VEC_LAST && !tamper_latch_q)
          state_d = any_reset ? `SRL_ST_RESET : `SRL_ST_RUN;
      end
      default:
        state_d = `SRL_ST_RESET;
    endcase
    // Any erase source overrides the choice above
    if (start_erase)
      state_d = `SRL_ST_ERASE;
  end

  // State, erase pointer, key and lock
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= `SRL_ST_RESET;
      erase_ptr_q <= 6'h0;
      tamper_latch_q <= 1'b0;
      key_word <= `SRL_KEY_RST;
      lock_state <= `SRL_LOCK_RST;
    end
    else
    begin
      state_q <= state_d;
      tamper_latch_q <= tmp_s;
      if (start_erase)
      begin
        key_word <= `SRL_KEY_RST;
        lock_state <= 1'b0;
        erase_ptr_q <= 6'h0;
      end
      else
      begin
        // Pointer walks once through the memory, then parks
        if (is_erase(state_q) && erase_ptr_q != `SRL_VEC_LAST)
          erase_ptr_q <= erase_ptr_q + 6'h1;
        // Key only from the generator, and only while unlocked in loader
        if (key_load_req && !lock_state && state_q == `SRL_ST_LOADER)
          key_word <= rng_key;
        // Lock can only be set from the loader
        if (lock_set_req && state_q == `SRL_ST_LOADER)
          lock_state <= 1'b1;
      end
    end
  end

  // Erase writes zero to every byte; user writes blocked meanwhile
  assign ram_we = is_erase(state_q) | (vec_we & (state_q != `SRL_ST_RESET));
  assign ram_waddr = is_erase(state_q) ? erase_ptr_q : vec_addr;
  assign ram_wdata = is_erase(state_q) ? 8'h00 : vec_wdata;

  // One write port shared by wiping and user writes
  srl_vec_ram u_vec
  (
    .ref_clk(ref_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(vec_addr),
    .rdata(ram_rdata)
  );

  // Pins and status; every output is a flip-flop
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vec_rdata <= 8'h00;
      core_reset <= 1'b1;
      loader_active <= 1'b0;
      low_supply_reset_out <= 1'b0;
      low_supply_reset_oe <= 1'b0;
      backup_active_flag <= 1'b1;
      backed_supply_output <= 1'b0;
      erase_busy <= 1'b0;
      sram_addr <= 15'h0000;
      sram_select_one <= 1'b1;
      sram_select_two <= 1'b1;
      sram_select_three <= 1'b1;
      sram_select_four <= 1'b1;
    end
    else
    begin
      // Reads masked while state_q is erase; if vec_addr is 47, its old byte shows the cycle after erase ends
      vec_rdata <= is_erase(state_q) ? 8'h00 : ram_rdata;
      core_reset <= (state_d == `SRL_ST_RESET) | is_erase(state_d);
      loader_active <= (state_d == `SRL_ST_LOADER);
      // Open drain: pin data always low, only the enable moves
      low_supply_reset_out <= 1'b0;
      low_supply_reset_oe <= supply_below_min & core_reset;
      // Switchover flag follows the lithium level; backed supply follows it too but also drops on tamper
      backup_active_flag <= ~supply_below_backup;
      backed_supply_output <= ~tmp_s & ~supply_below_backup;
      erase_busy <= is_erase(state_d);
      sram_addr <= mem_addr[14:0];
      // Selects parked high on low backup supply, and otherwise unless a live access in run or loader
      if (supply_below_backup || !mem_req || state_q != `SRL_ST_RUN
          && state_q != `SRL_ST_LOADER)
      begin
        sram_select_one <= 1'b1;
        sram_select_two <= 1'b1;
        sram_select_three <= 1'b1;
        sram_select_four <= 1'b1;
      end
      else if (memory_size_select)
      begin
        // Program in first 64kB, data in second: four 32kB parts
        {sram_select_four, sram_select_three, sram_select_two, sram_select_one}
          <= blk_sel({~mem_loader_request, mem_addr[15]});
      end
      else
      begin
        // One 128kB part: select two/three become A16/A15
        sram_select_one <= 1'b0;
        sram_select_two <= ~mem_loader_request;
        sram_select_three <= mem_addr[15];
        sram_select_four <= 1'b1;
      end
    end
  end
endmodule // srl_ctrl

// ---- rtl/srl_map.vh ----
// Constants for the secure reset, loader and tamper control block
`ifndef SRL_MAP_VH
`define SRL_MAP_VH
`define SRL_CLK_PERIOD_NS 100
`define SRL_KEY_W 64
`define SRL_VEC_DEPTH 48
`define SRL_VEC_AW 6
`define SRL_VEC_LAST 6'h2F
`define SRL_LOADER_MIN_CLKS 48
`define SRL_LOCK_RST 1'b0
`define SRL_KEY_RST 64'h0000000000000000
`define SRL_ST_RUN 2'h0
`define SRL_ST_RESET 2'h1
`define SRL_ST_LOADER 2'h2
`define SRL_ST_ERASE 2'h3
`endif

// ---- rtl/srl_vec_ram.v ----
// Vector memory of 48 bytes with registered read data
`timescale 1ns/100ps
module srl_vec_ram
(
  input wire ref_clk,
  input wire we,
  input wire [5:0] waddr,
  input wire [7:0] wdata,
  input wire [5:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:47];

  // Write port and registered read; no reset so it maps to plain RAM
  always @(posedge ref_clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule // srl_vec_ram

// ---- tb/srl_ctrl_assertions.sv ----
// Port checker for the reset, loader and tamper control block
`timescale 1ns/100ps
module srl_ctrl_assertions
(
  input wire ref_clk,
  input wire rstn,
  input wire reset_in,
  input wire low_supply_reset_in,
  input wire supply_below_min,
  input wire supply_below_backup,
  input wire tamper_destruct_input,
  input wire key_load_req,
  input wire core_reset,
  input wire low_supply_reset_oe,
  input wire low_supply_reset_out,
  input wire backup_active_flag,
  input wire backed_supply_output,
  input wire erase_busy,
  input wire [63:0] key_word,
  input wire sram_select_one,
  input wire sram_select_two,
  input wire sram_select_three,
  input wire sram_select_four
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Tamper seen long enough to get through both sync stages
  sequence s_tamper_seen;
    $rose(tamper_destruct_input) ##1 tamper_destruct_input [*2];
  endsequence
  sequence s_wiped;
    erase_busy && core_reset && !backed_supply_output && key_word == 64'h0;
  endsequence
  chk_pin_out_low: assert property (low_supply_reset_out == 1'b0)
    else $error("low-supply pin driven high");
  chk_low_supply_drive: assert property (supply_below_min && core_reset |-> ##[0:4] low_supply_reset_oe)
    else $error("low-supply pin not driven");
  chk_reset_pin_hold: assert property (reset_in [*5] |-> core_reset)
    else $error("reset pin did not hold core");
  chk_peer_reset: assert property (!low_supply_reset_in [*5] |-> core_reset)
    else $error("shared line low without reset");
  chk_backup_flag: assert property (supply_below_backup [*3] |-> !backup_active_flag)
    else $error("backup flag not low");
  chk_selects_idle: assert property (supply_below_backup [*3] |-> sram_select_one && sram_select_two
    && sram_select_three && sram_select_four)
    else $error("select active on backup");
  chk_tamper_wipe: assert property (s_tamper_seen |-> ##[0:2] s_wiped)
    else $error("tamper did not wipe");
  chk_erase_holds: assert property (erase_busy |-> core_reset && key_word == 64'h0)
    else $error("core running during erase");
  chk_key_source: assert property ($changed(key_word) |-> key_word == 64'h0 || $past(key_load_req))
    else $error("key changed from outside");
endmodule // srl_ctrl_assertions
bind srl_ctrl srl_ctrl_assertions i_srl_ctrl_assertions (.*);

// ---- tb/srl_far_model.sv ----
// Shared open-drain low-supply line with a peer device on it
`timescale 1ns/100ps
module srl_far_model
(
  input wire peer_pull,
  input wire low_supply_reset_oe,
  output wire low_supply_reset_in
);
  // Pull-up wins unless some party sinks the line
  assign low_supply_reset_in = ~(peer_pull | low_supply_reset_oe);
endmodule // srl_far_model

// ---- tb/srl_ctrl_tb.sv ----
// Directed bench for the reset, loader and tamper control block
`timescale 1ns/100ps
module srl_ctrl_tb;
  logic ref_clk = 0, rstn = 0, reset_in = 0, loader_request = 1, supply_below_min = 0;
  logic supply_below_backup = 0, tamper_destruct_input = 0, memory_size_select = 1;
  logic lock_clear_req = 0, key_load_req = 0, mem_req = 0, mem_loader_request = 0, peer_pull = 0;
  logic [63:0] rng_key = 64'hA5C30F1E77882B4D;
  logic [15:0] mem_addr = 16'h0000;
  // Vector port and probe input, driven by the wipe scenarios
  logic key_probe_detect = 0, lock_set_req = 0, vec_we = 0;
  logic [5:0] vec_addr = 6'h00;
  logic [7:0] vec_wdata = 8'h00, vec_rdata;
  logic core_reset, loader_active, low_supply_reset_out, low_supply_reset_oe;
  logic backup_active_flag, backed_supply_output, erase_busy, lock_state;
  logic sram_select_one, sram_select_two, sram_select_three, sram_select_four;
  logic [63:0] key_word;
  logic [14:0] sram_addr;
  wire low_supply_reset_in;
  int n_errors = 0, cmp_count = 0;
  always #50 ref_clk = ~ref_clk;
  srl_ctrl i_srl_ctrl (.*);
  srl_far_model i_srl_far_model (.*);
  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs always move a fixed 10 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_for(ref logic s, input logic v);
    for (int i = 0; i < 200 && s !== v; i++)
      cyc(1);
    if (s !== v)
    begin
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(1);
  endtask
  task automatic t_reset_pin;
    reset_in = 1;
    cyc(8);
    chk(core_reset, 1);
    reset_in = 0;
    wait_for(core_reset, 0);
  endtask
  // Every block in both size modes
  task automatic t_memmap;
    logic [3:0] exp;
    mem_req = 1;
    for (int b = 0; b < 8; b++)
    begin
      memory_size_select = b[2];
      mem_loader_request = ~b[1];
      mem_addr = {b[0], 15'h1234};
      cyc(2);
      exp = b[2] ? ~(4'h1 << b[1:0]) : {1'b1, b[0], b[1], 1'b0};
      chk({sram_select_four, sram_select_three, sram_select_two, sram_select_one}, exp);
      chk(sram_addr, 15'h1234);
    end
  endtask
  // Selects stay parked while the line and flag report low supply
  task automatic t_supply;
    {supply_below_backup, supply_below_min, reset_in} = 3'b111;
    cyc(6);
    chk({low_supply_reset_in, backup_active_flag}, 2'b00);
    chk({sram_select_four, sram_select_three, sram_select_two, sram_select_one}, 4'hF);
    {supply_below_backup, supply_below_min, reset_in} = 3'b000;
    wait_for(core_reset, 0);
    peer_pull = 1;
    cyc(6);
    chk(core_reset, 1);
    peer_pull = 0;
    wait_for(core_reset, 0);
  endtask
  // Enter the loader by a held low request and load a fresh key
  task automatic enter_loader;
    loader_request = 1;
    cyc(4);
    loader_request = 0;
    wait_for(loader_active, 1);
    cyc(48);
    pulse(key_load_req);
    chk(key_word, rng_key);
  endtask
  // Tamper lands in the loader after the key load, and a reset must not cut the erase short
  task automatic t_loader_tamper;
    enter_loader();
    tamper_destruct_input = 1;
    cyc(4);
    chk({erase_busy, core_reset, backed_supply_output}, 3'b110);
    chk(key_word, 64'h0);
    tamper_destruct_input = 0;
    reset_in = 1;
    cyc(10);
    chk(erase_busy, 1);
    reset_in = 0;
    wait_for(erase_busy, 0);
  endtask
  // A probe attempt wipes a freshly loaded key
  task automatic t_probe;
    enter_loader();
    pulse(key_probe_detect);
    chk(erase_busy, 1);
    chk(key_word, 64'h0);
    wait_for(erase_busy, 0);
  endtask
  // Lock refuses reloads; clearing it wipes key and vector bytes
  task automatic t_lock_wipe;
    enter_loader();
    vec_addr = 6'h05;
    vec_wdata = 8'h5A;
    pulse(vec_we);
    cyc(1);
    chk(vec_rdata, 8'h5A);
    pulse(lock_set_req);
    chk(lock_state, 1);
    rng_key = 64'h0123456789ABCDEF;
    pulse(key_load_req);
    chk(key_word, 64'hA5C30F1E77882B4D);
    pulse(lock_clear_req);
    chk({erase_busy, lock_state}, 2'b10);
    chk(key_word, 64'h0);
    wait_for(erase_busy, 0);
    cyc(2);
    chk(vec_rdata, 8'h00);
    loader_request = 1;
    wait_for(core_reset, 0);
  endtask
  initial
  begin
    cyc(6);
    rstn = 1;
    wait_for(core_reset, 0);
    t_reset_pin();
    t_memmap();
    t_supply();
    t_loader_tamper();
    t_probe();
    t_lock_wipe();
    tally_and_finish();
  end
endmodule // srl_ctrl_tb
